/* File: hw/irp_pkg.sv */
// irp_pkg: constants and the APB request type for the front sensor array readout.
// assumes a single 50 MHz clock and an APB master with 32-bit data.
package irp_pkg;
   // register map, one aligned word each
   localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
   // control fields: jumper selects for the shared pins
   localparam int unsigned CTRL_SEL_LEFT  = 0;
   localparam int unsigned CTRL_SEL_RIGHT = 1;
   localparam logic [1:0]  CTRL_RESET     = 2'h3;   // both pins carry proximity receivers
   // status fields
   localparam int unsigned STAT_DET_LSB   = 0;     // [2:0] left, front, right detect
   localparam int unsigned STAT_LEFT_LIT  = 3;
   localparam int unsigned STAT_RIGHT_LIT = 4;
   localparam int unsigned STAT_LINE_LIT  = 5;
   localparam int unsigned STAT_CHG_LSB   = 6;     // [10:6] line sensor charge state
   // pad positions, pad 0 is line sensor 1 (leftmost)
   localparam int unsigned PAD_LEFT_SHARED  = 1;
   localparam int unsigned PAD_RIGHT_SHARED = 3;
   localparam int unsigned DET_LEFT  = 0;
   localparam int unsigned DET_FRONT = 1;
   localparam int unsigned DET_RIGHT = 2;
   // timing
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned CARRIER_HZ   = 38_000;
   localparam int unsigned TOL_PCT      = 10;      // accepted period spread
   localparam int unsigned PER_MIN_CYC  =
      (CLK_HZ + (CARRIER_HZ * (100 + TOL_PCT) / 100) - 1) / (CARRIER_HZ * (100 + TOL_PCT) / 100);
   localparam int unsigned PER_MAX_CYC  = CLK_HZ / (CARRIER_HZ * (100 - TOL_PCT) / 100);
   localparam int unsigned LOCK_PERIODS = 4;
   localparam int unsigned PER_W        = 12;
   localparam int unsigned DECAY_W      = 12;
   localparam logic [8:0]  DECAY_FULL   = 9'h100;  // decay units with no reflection

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } irp_apb_req_s;
endpackage

/* File: hw/irp_carrier_det.sv */
// irp_carrier_det: one infrared receiver, detects light keyed at the carrier rate.
// assumes light_i is synchronous to sys_clk_i; steady light never detects.
`timescale 1ns/100ps
module irp_carrier_det #(
   parameter int unsigned PER_MIN = irp_pkg::PER_MIN_CYC,
   parameter int unsigned PER_MAX = irp_pkg::PER_MAX_CYC,
   parameter int unsigned LOCK    = irp_pkg::LOCK_PERIODS
)(
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic ce_i,
   input  wire logic light_i,
   output logic      detect_o
);
   logic                      light_q;
   logic [irp_pkg::PER_W-1:0] per_q;
   logic [2:0]                good_q;
   logic                      det_q;

   // period between rising light edges, saturating once stale
   wire rise   = light_i & ~light_q;
   wire in_win = (per_q >= irp_pkg::PER_W'(PER_MIN)) && (per_q <= irp_pkg::PER_W'(PER_MAX));
   wire stale  = per_q > irp_pkg::PER_W'(PER_MAX);
   wire lock   = good_q >= 3'(LOCK - 1);
   wire accept = rise & in_win;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         light_q <= 1'b0;
         per_q   <= '0;
         good_q  <= 3'h0;
         det_q   <= 1'b0;
      end else if (ce_i) begin
         light_q <= light_i;
         if (rise)
            per_q <= irp_pkg::PER_W'(1);
         else if (!stale)
            per_q <= per_q + irp_pkg::PER_W'(1);
         if (rise)
            good_q <= in_win ? (lock ? good_q : good_q + 3'h1) : 3'h0;
         else if (stale)
            good_q <= 3'h0;
         if (rise)
            det_q <= in_win & lock;
         else if (stale)
            det_q <= 1'b0;
      end
   end

   assign detect_o = det_q;

   property p_det_lock;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(det_q) |-> $past(accept) && ($past(good_q) >= 3'(LOCK - 1));
   endproperty
   a_det_lock: assert property (p_det_lock) else $error("detect rose unlocked");

   property p_det_stale;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ce_i && stale && !rise) |=> !det_q;
   endproperty
   a_det_stale: assert property (p_det_stale) else $error("detect held without carrier");
endmodule // irp_carrier_det

/* File: hw/irp_front_array.sv */
// irp_front_array: front sensor board model with emitter control and APB status.
// assumes the host drives the emitter controls and line charge synchronously;
// the bench resolves pad wires from pad_out_o/pad_oe_o plus host drive and pull-ups.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
module irp_front_array #(
   parameter int unsigned DECAY_SCALE = 4
)(
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  ce_i,
   input  wire irp_pkg::irp_apb_req_s apb_i,
   output logic                       pready_o,
   output logic                       pslverr_o,
   output logic [31:0]                prdata_o,
   input  wire logic                  line_emitter_enable_i,
   input  wire logic                  emitter_pwm_drive_i,
   input  wire logic                  emitter_side_select_i,
   input  wire logic [4:0]            line_charge_i,
   input  wire logic [4:0][7:0]       floor_reflect_i,
   input  wire logic [2:0]            prox_light_i,
   output logic [4:0]                 pad_out_o,
   output logic [4:0]                 pad_oe_o,
   output logic                       front_out_o,
   output logic                       front_oe_o,
   output logic                       line_emit_lit_o,
   output logic                       left_group_lit_o,
   output logic                       right_group_lit_o
);
   logic [1:0]  ctrl_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        line_lit_q;
   logic        left_lit_q;
   logic        right_lit_q;
   logic [4:0]  pad_out_q;
   logic [4:0]  pad_oe_q;
   logic        front_oe_q;
   logic [2:0]  det;
   logic [4:0]  charged;

   // apb decode
   wire setup     = apb_i.psel & ~apb_i.penable;
   wire hit_ctrl  = apb_i.paddr == irp_pkg::ADDR_CTRL;
   wire hit_stat  = apb_i.paddr == irp_pkg::ADDR_STATUS;
   wire mapped    = hit_ctrl | hit_stat;
   wire wr_ctrl   = apb_i.psel & apb_i.penable & pready_q & apb_i.pwrite & hit_ctrl;
   wire [31:0] status_w = {21'h0, charged, line_lit_q, right_lit_q, left_lit_q, det};
   wire [31:0] rdata_w  = hit_ctrl ? {30'h0, ctrl_q} : (hit_stat ? status_w : 32'h0);

   // register file; data is latched in setup so access has zero wait states
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         ctrl_q    <= irp_pkg::CTRL_RESET;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else if (ce_i) begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup)
            prdata_q <= apb_i.pwrite ? 32'h0 : rdata_w;
         if (wr_ctrl)
            ctrl_q <= apb_i.pwdata[1:0];
      end
   end

   // emitter drive: groups are series pairs, so one select lights a whole side
   wire left_d  = emitter_pwm_drive_i & ~emitter_side_select_i;
   wire right_d = emitter_pwm_drive_i &  emitter_side_select_i;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         line_lit_q  <= 1'b1;
         left_lit_q  <= 1'b0;
         right_lit_q <= 1'b0;
      end else if (ce_i) begin
         line_lit_q  <= line_emitter_enable_i;
         left_lit_q  <= left_d;
         right_lit_q <= right_d;
      end
   end

   // one carrier detector per receiver: left, front, right
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_rx
         irp_carrier_det u_det (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .ce_i      (ce_i),
            .light_i   (prox_light_i[g]),
            .detect_o  (det[g])
         );
      end
   endgenerate

   // line sensor pads; a darker floor or dark emitters mean a slower decay
   generate
      for (g = 0; g < 5; g++) begin : g_line
         localparam bit          SHARED = (g == irp_pkg::PAD_LEFT_SHARED) ||
                                          (g == irp_pkg::PAD_RIGHT_SHARED);
         localparam int unsigned DSEL   = (g == irp_pkg::PAD_LEFT_SHARED) ?
                                          irp_pkg::DET_LEFT : irp_pkg::DET_RIGHT;
         localparam int unsigned CSEL   = (g == irp_pkg::PAD_LEFT_SHARED) ?
                                          irp_pkg::CTRL_SEL_LEFT : irp_pkg::CTRL_SEL_RIGHT;
         logic [irp_pkg::DECAY_W-1:0] decay_q;
         wire  [8:0]  dark  = line_lit_q ? irp_pkg::DECAY_FULL - {1'b0, floor_reflect_i[g]}
                                         : irp_pkg::DECAY_FULL;
         wire  [irp_pkg::DECAY_W-1:0] load = irp_pkg::DECAY_W'(dark * DECAY_SCALE);
         wire  prox_sel = SHARED && ctrl_q[CSEL];
         assign charged[g] = decay_q != '0;

         always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
               decay_q      <= '0;
               pad_out_q[g] <= 1'b0;
               pad_oe_q[g]  <= 1'b0;
            end else if (ce_i) begin
               if (line_charge_i[g])
                  decay_q <= load;
               else if (charged[g])
                  decay_q <= decay_q - irp_pkg::DECAY_W'(1);
               if (prox_sel) begin
                  pad_out_q[g] <= 1'b0;
                  pad_oe_q[g]  <= det[DSEL];
               end else begin
                  pad_out_q[g] <= charged[g];
                  pad_oe_q[g]  <= ~line_charge_i[g];
               end
            end
         end
      end
   endgenerate

   // front receiver has its own pin, open drain
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i)
         front_oe_q <= 1'b0;
      else if (ce_i)
         front_oe_q <= det[irp_pkg::DET_FRONT];
   end

   assign pready_o          = pready_q;
   assign pslverr_o         = pslverr_q;
   assign prdata_o          = prdata_q;
   assign pad_out_o         = pad_out_q;
   assign pad_oe_o          = pad_oe_q;
   assign front_out_o       = 1'b0;
   assign front_oe_o        = front_oe_q;
   assign line_emit_lit_o   = line_lit_q;
   assign left_group_lit_o  = left_lit_q;
   assign right_group_lit_o = right_lit_q;

   property p_emit_follow;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      ce_i |=> line_emit_lit_o == $past(line_emitter_enable_i);
   endproperty
   a_emit_follow: assert property (p_emit_follow) else $error("line emitters ignore enable");

   property p_group_excl;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      !(left_group_lit_o && right_group_lit_o);
   endproperty
   a_group_excl: assert property (p_group_excl) else $error("both emitter groups lit");

   property p_group_side;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ce_i && emitter_pwm_drive_i) |=>
         (right_group_lit_o == $past(emitter_side_select_i)) &&
         (left_group_lit_o != right_group_lit_o);
   endproperty
   a_group_side: assert property (p_group_side) else $error("wrong emitter group lit");

   property p_group_dark;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ce_i && !emitter_pwm_drive_i) |=> !left_group_lit_o && !right_group_lit_o;
   endproperty
   a_group_dark: assert property (p_group_dark) else $error("emitter lit with drive low");

   property p_prox_pull;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ce_i && ctrl_q[irp_pkg::CTRL_SEL_LEFT] && det[irp_pkg::DET_LEFT]) |=>
         pad_oe_o[irp_pkg::PAD_LEFT_SHARED] && !pad_out_o[irp_pkg::PAD_LEFT_SHARED];
   endproperty
   a_prox_pull: assert property (p_prox_pull) else $error("left receiver not pulling low");

   property p_shared_line;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ce_i && !ctrl_q[irp_pkg::CTRL_SEL_RIGHT]) |=>
         pad_oe_o[irp_pkg::PAD_RIGHT_SHARED] == !$past(line_charge_i[irp_pkg::PAD_RIGHT_SHARED]);
   endproperty
   a_shared_line: assert property (p_shared_line) else $error("right pad not a line sensor");

   sequence s_charge_one;
      (ce_i && line_charge_i[0]) ##1 ce_i;
   endsequence
   property p_sensor_one;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      s_charge_one |=> pad_out_o[0];
   endproperty
   a_sensor_one: assert property (p_sensor_one) else $error("pad 0 not charged");

   property p_apb_ready;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (ce_i && setup) |=> pready_o && (pslverr_o == !$past(mapped));
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer missing");
endmodule // irp_front_array

/* File: test/irp_host_model.sv */
// irp_host_model: host side of the front sensor board, emitter drive and pad pull-ups.
// assumes the bench requests charge pulses and carrier bursts just after a rising edge.
`timescale 1ns/100ps
module irp_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       burst_i,
   input  wire logic       level_i,
   input  wire logic [4:0] charge_req_i,
   input  wire logic [4:0] pad_out_i,
   input  wire logic [4:0] pad_oe_i,
   input  wire logic       front_out_i,
   input  wire logic       front_oe_i,
   output logic            pwm_o,
   output logic [4:0]      line_charge_o,
   output logic [4:0]      pad_level_o,
   output logic            front_level_o
);
   logic [10:0] cnt_q;
   // carrier period counter, 1316 cycles at 50 MHz
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || cnt_q == 11'h523)
         cnt_q <= 11'h000;
      else
         cnt_q <= cnt_q + 11'h001;
   end
   // drive high lights group, half duty sets brightness
   assign pwm_o = burst_i ? (cnt_q < 11'h292) : level_i;
   // host drives the pad high only while charging
   assign line_charge_o = charge_req_i;
   // released lines read through the host pull-up, so idle reads high
   assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i);
   assign front_level_o = front_oe_i ? front_out_i : 1'b1;
endmodule // irp_host_model

/* File: test/tb_ir_line_proximity_readout.sv */
// tb_ir_line_proximity_readout: self-checking bench for the front sensor array.
// assumes irp_pkg and the host model are compiled first; decay scale is 1.
`timescale 1ns/100ps
module tb_ir_line_proximity_readout;
   logic                  sys_clk, rst_b, pready, pslverr, line_en, side, level, burst;
   logic                  steady, pwm, front_out, front_oe, line_lit, left_lit, right_lit;
   logic                  front_level, err, ce;
   irp_pkg::irp_apb_req_s apb;
   logic [31:0]           prdata, rd, r, seed;
   logic [4:0]            charge_req, line_charge, pad_out, pad_oe, pad_level;
   logic [4:0][7:0]       reflect;
   logic [2:0]            light;
   int                    n_fail, n_tests, cyc, i;

   irp_front_array #(.DECAY_SCALE(1)) uut (
      .sys_clk_i(sys_clk), .rst_b_i(rst_b), .ce_i(ce), .apb_i(apb), .pready_o(pready),
      .pslverr_o(pslverr), .prdata_o(prdata), .line_emitter_enable_i(line_en),
      .emitter_pwm_drive_i(pwm), .emitter_side_select_i(side), .line_charge_i(line_charge),
      .floor_reflect_i(reflect), .prox_light_i(light), .pad_out_o(pad_out),
      .pad_oe_o(pad_oe), .front_out_o(front_out), .front_oe_o(front_oe),
      .line_emit_lit_o(line_lit), .left_group_lit_o(left_lit), .right_group_lit_o(right_lit));
   irp_host_model host (
      .sys_clk_i(sys_clk), .rst_b_i(rst_b), .burst_i(burst), .level_i(level),
      .charge_req_i(charge_req), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
      .front_out_i(front_out), .front_oe_i(front_oe), .pwm_o(pwm),
      .line_charge_o(line_charge), .pad_level_o(pad_level), .front_level_o(front_level));

   // reflected light reaches every receiver while a group is lit
   assign light = steady ? 3'h7 : {3{left_lit | right_lit}};

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic conclude();
      if (n_fail == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; waits on pready, the bench timeout ends a hang
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      @(posedge sys_clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge sys_clk);
      apb.penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb <= '0;
   endtask

   // hang guard, sized well above the longest sequence
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         conclude();
      end
   end

   // one line charge of the given pads, then released
   task automatic charge(input logic [4:0] pads);
      charge_req <= pads;
      @(posedge sys_clk);
      charge_req <= 5'h00;
      repeat (3) @(posedge sys_clk);
   endtask

   initial begin
      seed = 32'h0e59ed03;
      {rst_b, line_en, side, level, burst, steady, charge_req, n_fail, n_tests, cyc} = '0;
      line_en = 1'b1;
      ce = 1'b1;
      apb = '0;
      reflect = '0;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      check("line_lit", line_lit, 1);
      check("groups", {left_lit, right_lit}, 0);
      xfer(1'b0, irp_pkg::ADDR_CTRL, 0);
      check("ctrl", rd, 3);
      xfer(1'b0, 32'h8, 0);
      check("unmapped_err", err, 1);
      check("unmapped_rd", rd, 0);
      xfer(1'b1, irp_pkg::ADDR_STATUS, 32'hffffffff);
      check("ro_err", err, 0);
      // random emitter control, lit state one edge later
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         line_en <= r[0];
         level <= r[1];
         side <= r[2];
         repeat (2) @(posedge sys_clk);
         check("left", left_lit, r[1] & ~r[2]);
         check("right", right_lit, r[1] & r[2]);
         check("line", line_lit, r[0]);
      end
      // clock enable low freezes the lit state against a changed enable
      ce <= 1'b0;
      line_en <= ~r[0];
      repeat (3) @(posedge sys_clk);
      check("ce_hold", line_lit, r[0]);
      ce <= 1'b1;
      // line emitters dark before carrier bursts
      line_en <= 1'b0;
      level <= 1'b0;
      // left group burst first, then right group
      for (i = 0; i < 2; i++) begin
         side <= i[0];
         burst <= 1'b1;
         repeat (8000) @(posedge sys_clk);
         check("front_oe", front_oe, 1);
         check("front_lvl", front_level, 0);
         // discharged line pads are held low, receivers pull pads 1 and 3 low
         check("pads", pad_level, 5'h00);
         xfer(1'b0, irp_pkg::ADDR_STATUS, 0);
         check("det", rd[2:0], 3'h7);
         burst <= 1'b0;
         repeat (3000) @(posedge sys_clk);
         // released receiver pins float to the pull-up, line pads stay low
         check("dark", {front_level, pad_level}, 6'h2a);
      end
      steady <= 1'b1;
      repeat (8000) @(posedge sys_clk);
      check("steady", {front_oe, pad_oe[3], pad_oe[1]}, 0);
      steady <= 1'b0;
      // line sensor 5 decay follows its own reflectance
      line_en <= 1'b1;
      r = 40 + ($random(seed) & 127);
      reflect[4] <= r[7:0];
      // the charge edge must already see the line emitters lit
      @(posedge sys_clk);
      charge(5'h13);
      check("chg_hi", pad_level[4], 1);
      check("shared_prox", pad_oe[1], 0);
      repeat (256 - r - 14) @(posedge sys_clk);
      check("decay_hi", pad_level[4], 1);
      repeat (24) @(posedge sys_clk);
      check("decay_lo", pad_level[4], 0);
      // dark line emitters give the full decay
      line_en <= 1'b0;
      repeat (2) @(posedge sys_clk);
      charge(5'h10);
      repeat (256 - r + 10) @(posedge sys_clk);
      check("dark_decay", pad_level[4], 1);
      // shared pads switched to line sensors 2 and 4
      xfer(1'b1, irp_pkg::ADDR_CTRL, 0);
      xfer(1'b0, irp_pkg::ADDR_CTRL, 0);
      check("ctrl_wr", rd, 0);
      charge(5'h02);
      check("shared_line", {pad_oe[1], pad_out[1]}, 2'h3);
      conclude();
   end
endmodule // tb_ir_line_proximity_readout
